/* File: rtcia_regs.svh */
// register offsets, key codes, field positions and timing counts of the
// locked indirect-access window; definitions only
`ifndef RTCIA_REGS_SVH
`define RTCIA_REGS_SVH

`define RTCIA_ADR_OFS 8'hAC
`define RTCIA_DAT_OFS 8'hAD
`define RTCIA_KEY_OFS 8'hAE

`define RTCIA_ADR_RST 8'h00
`define RTCIA_DAT_RST 8'h00

`define RTCIA_KEY_FIRST 8'hA5
`define RTCIA_KEY_SECOND 8'hF1

`define RTCIA_CODE_LOCKED 8'h00
`define RTCIA_CODE_WAIT 8'h01
`define RTCIA_CODE_OPEN 8'h02
`define RTCIA_CODE_DEAD 8'h03

`define RTCIA_BIT_BUSY 7
`define RTCIA_BIT_AUTO_READ_ENABLE 6
`define RTCIA_BIT_UNUSED 5
`define RTCIA_BIT_SHORT 4
`define RTCIA_ADDR_MSB 3

`define RTCIA_CAP_FIRST 4'h0
`define RTCIA_CAP_LAST 4'h3
`define RTCIA_ALM_FIRST 4'h8
`define RTCIA_ALM_LAST 4'hB

`define RTCIA_CYC_NORMAL 7
`define RTCIA_CYC_SHORT 6

`endif

/* File: rtcia_pkg.sv */
// types shared by the indirect-access window
// assumes rtcia_regs.svh supplies the numeric constants
package rtcia_pkg;
    typedef enum logic [1:0] {
        RTCIA_LOCKED,
        RTCIA_WAIT,
        RTCIA_OPEN,
        RTCIA_DEAD
    } rtcia_lock_e;
endpackage

/* File: rtcia_strobe_timer.sv */
// access strobe timer: measures one indirect transfer in system clocks
// assumes start is a one-cycle pulse that never arrives while running
`timescale 1ns/1ps
`include "rtcia_regs.svh"
module rtcia_strobe_timer #(
    parameter int unsigned CYC_NORMAL = `RTCIA_CYC_NORMAL,
    parameter int unsigned CYC_SHORT = `RTCIA_CYC_SHORT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic short_en,
    output logic done
);
    logic run_r;
    logic run_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;

    // done stays combinational so the owner clears busy on the last edge
    assign done = run_r && (cnt_r == 4'h0);

    always_comb begin
        run_nxt = run_r;
        cnt_nxt = cnt_r;
        if (start) begin
            run_nxt = 1'b1;
            cnt_nxt = short_en ? 4'(CYC_SHORT - 1) : 4'(CYC_NORMAL - 1); // [RULE13] [RULE14]
        end else if (done) begin
            run_nxt = 1'b0;
        end else if (run_r) begin
            cnt_nxt = cnt_r - 4'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_r <= 1'b0;
            cnt_r <= 4'h0;
        end else begin
            run_r <= run_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule // rtcia_strobe_timer

/* File: rtcia_window.sv */
// locked indirect-access window: key, address and data registers on the
// special function register bus, and the strobe side to the clock core
// assumes the bus gives one-cycle rd/wr strobes and that the clock core
// holds rtc_rdata steady for the addressed byte while a read runs
`timescale 1ns/1ps
`include "rtcia_regs.svh"

// Behaviour
// [RULE1] key read shows lock state code
// [RULE2] A5 then F1 unlocks the window
// [RULE3] wrong second key disables until reset
// [RULE4] any key write while unlocked relocks
// [RULE5] disabled state ignores all key writes
// [RULE6] wrong first key or locked access disables
// [RULE7] busy bit shows transfer, writing starts read
// [RULE8] busy holds until transfer completes
// [RULE9] data write while unlocked starts indirect write
// [RULE10] bit 6 enables auto-read
// [RULE11] auto-read: data read launches next read
// [RULE12] bit 5 reads zero, writes ignored
// [RULE13] bit 4 selects short strobe timing
// [RULE14] transfer takes 7 cycles, 6 when short
// [RULE15] low four bits select internal register
// [RULE16] address increments after snapshot or alarm access
// [RULE17] snapshot low, alarm high, others no increment
// [RULE18] data register holds last transferred byte
// [RULE19] software avoids read-modify-write on data
// [RULE20] key read leaves sequence undisturbed
module rtcia_window (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic [7:0] rtc_rdata,
    output logic [3:0] rtc_addr,
    output logic [7:0] rtc_wdata,
    output logic rtc_wr,
    output logic rtc_rd,
    output logic [1:0] lock_machine_state
);
    rtcia_pkg::rtcia_lock_e lock_r;
    rtcia_pkg::rtcia_lock_e lock_nxt;
    logic busy_r, busy_nxt;
    logic auto_read_enable_r, auto_read_enable_nxt;
    logic short_r, short_nxt;
    logic [3:0] addr_r, addr_nxt;
    logic [7:0] data_r, data_nxt;
    logic wr_op_r, wr_op_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rtc_wr_r, rtc_wr_nxt;
    logic rtc_rd_r, rtc_rd_nxt;
    logic start;
    logic done;
    logic key_wr, adr_wr, dat_wr, dat_rd;
    logic is_open, is_locked;

    function automatic logic [7:0] lock_code(input rtcia_pkg::rtcia_lock_e s);
        case (s)
            rtcia_pkg::RTCIA_LOCKED: lock_code = `RTCIA_CODE_LOCKED;
            rtcia_pkg::RTCIA_WAIT: lock_code = `RTCIA_CODE_WAIT;
            rtcia_pkg::RTCIA_OPEN: lock_code = `RTCIA_CODE_OPEN;
            default: lock_code = `RTCIA_CODE_DEAD;
        endcase
    endfunction

    function automatic logic auto_inc(input logic [3:0] a);
        auto_inc = (a <= `RTCIA_CAP_LAST) ||
            (a >= `RTCIA_ALM_FIRST && a <= `RTCIA_ALM_LAST); // [RULE17]
    endfunction

    function automatic logic [7:0] adr_view(input logic b, input logic ar,
            input logic sh, input logic [3:0] a);
        adr_view = 8'h00;
        adr_view[`RTCIA_BIT_BUSY] = b;
        adr_view[`RTCIA_BIT_AUTO_READ_ENABLE] = ar;
        adr_view[`RTCIA_BIT_SHORT] = sh;
        adr_view[`RTCIA_ADDR_MSB:0] = a; // [RULE12]
    endfunction

    rtcia_strobe_timer #(
        .CYC_NORMAL(`RTCIA_CYC_NORMAL),
        .CYC_SHORT(`RTCIA_CYC_SHORT)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .start(start),
        // next value, so one write that sets short and busy already runs short
        .short_en(short_nxt),
        .done(done)
    );

    assign key_wr = sfr_wr && (sfr_addr == `RTCIA_KEY_OFS);
    assign adr_wr = sfr_wr && (sfr_addr == `RTCIA_ADR_OFS);
    assign dat_wr = sfr_wr && (sfr_addr == `RTCIA_DAT_OFS);
    assign dat_rd = sfr_rd && (sfr_addr == `RTCIA_DAT_OFS);
    assign is_open = (lock_r == rtcia_pkg::RTCIA_OPEN);
    assign is_locked = (lock_r == rtcia_pkg::RTCIA_LOCKED) ||
        (lock_r == rtcia_pkg::RTCIA_WAIT);

    always_comb begin
        lock_nxt = lock_r;
        busy_nxt = busy_r;
        auto_read_enable_nxt = auto_read_enable_r;
        short_nxt = short_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        wr_op_nxt = wr_op_r;
        rdata_nxt = rdata_r;
        rtc_wr_nxt = 1'b0;
        rtc_rd_nxt = 1'b0;
        start = 1'b0;

        if (key_wr) begin
            case (lock_r)
                rtcia_pkg::RTCIA_LOCKED: begin
                    lock_nxt = (sfr_wdata == `RTCIA_KEY_FIRST) ?
                        rtcia_pkg::RTCIA_WAIT : rtcia_pkg::RTCIA_DEAD; // [RULE2] [RULE6]
                end
                rtcia_pkg::RTCIA_WAIT: begin
                    lock_nxt = (sfr_wdata == `RTCIA_KEY_SECOND) ?
                        rtcia_pkg::RTCIA_OPEN : rtcia_pkg::RTCIA_DEAD; // [RULE2] [RULE3]
                end
                rtcia_pkg::RTCIA_OPEN: lock_nxt = rtcia_pkg::RTCIA_LOCKED; // [RULE4]
                rtcia_pkg::RTCIA_DEAD: lock_nxt = rtcia_pkg::RTCIA_DEAD; // [RULE5]
                default: lock_nxt = rtcia_pkg::RTCIA_DEAD;
            endcase
        end

        // an indirect access tried before unlock kills the window until reset
        if (is_locked && ((adr_wr && sfr_wdata[`RTCIA_BIT_BUSY]) || dat_wr)) begin
            lock_nxt = rtcia_pkg::RTCIA_DEAD; // [RULE6]
        end

        // while busy, address and data writes and auto-read launches are dropped [RULE8]
        if (is_open && !busy_r) begin
            if (adr_wr) begin
                auto_read_enable_nxt = sfr_wdata[`RTCIA_BIT_AUTO_READ_ENABLE]; // [RULE10]
                short_nxt = sfr_wdata[`RTCIA_BIT_SHORT]; // [RULE13]
                addr_nxt = sfr_wdata[`RTCIA_ADDR_MSB:0]; // [RULE15]
                if (sfr_wdata[`RTCIA_BIT_BUSY]) begin
                    start = 1'b1; // [RULE7]
                    wr_op_nxt = 1'b0;
                end
            end else if (dat_wr) begin
                data_nxt = sfr_wdata; // [RULE9] [RULE18]
                start = 1'b1;
                wr_op_nxt = 1'b1;
            end else if (dat_rd && auto_read_enable_r) begin
                start = 1'b1; // [RULE11]
                wr_op_nxt = 1'b0;
            end
        end

        if (start) begin
            busy_nxt = 1'b1; // [RULE7] [RULE8]
            rtc_rd_nxt = !wr_op_nxt;
        end

        if (done) begin
            busy_nxt = 1'b0; // [RULE8] [RULE14]
            if (wr_op_r) begin
                rtc_wr_nxt = 1'b1;
            end else begin
                data_nxt = rtc_rdata; // [RULE18]
            end
            if (auto_inc(addr_r)) begin
                addr_nxt = addr_r + 4'h1; // [RULE16]
            end
        end

        // reads never touch the lock machine [RULE20]
        if (sfr_rd) begin
            case (sfr_addr)
                `RTCIA_KEY_OFS: rdata_nxt = lock_code(lock_r); // [RULE1]
                `RTCIA_ADR_OFS: rdata_nxt = is_open ?
                    adr_view(busy_r, auto_read_enable_r, short_r, addr_r) : 8'h00;
                `RTCIA_DAT_OFS: rdata_nxt = is_open ? data_r : 8'h00;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_r <= rtcia_pkg::RTCIA_LOCKED;
            busy_r <= 1'b0;
            auto_read_enable_r <= 1'b0;
            short_r <= 1'b0;
            addr_r <= 4'h0;
            data_r <= `RTCIA_DAT_RST;
            wr_op_r <= 1'b0;
            rdata_r <= 8'h00;
            rtc_wr_r <= 1'b0;
            rtc_rd_r <= 1'b0;
        end else begin
            lock_r <= lock_nxt;
            busy_r <= busy_nxt;
            auto_read_enable_r <= auto_read_enable_nxt;
            short_r <= short_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            wr_op_r <= wr_op_nxt;
            rdata_r <= rdata_nxt;
            rtc_wr_r <= rtc_wr_nxt;
            rtc_rd_r <= rtc_rd_nxt;
        end
    end

    assign sfr_rdata = rdata_r;
    assign rtc_addr = addr_r;
    assign rtc_wdata = data_r;
    assign rtc_wr = rtc_wr_r;
    assign rtc_rd = rtc_rd_r;
    assign lock_machine_state = lock_r;

    property p_key_read;
        @(posedge clk) disable iff (rst)
        (sfr_rd && sfr_addr == `RTCIA_KEY_OFS) |=>
            sfr_rdata == lock_code($past(lock_r)) && lock_r == $past(lock_r);
    endproperty
    a_key_read: assert property (p_key_read) else $error("key read wrong"); // [RULE1]

    property p_first_key;
        @(posedge clk) disable iff (rst)
        (key_wr && lock_r == rtcia_pkg::RTCIA_LOCKED && sfr_wdata == `RTCIA_KEY_FIRST) |=>
            lock_r == rtcia_pkg::RTCIA_WAIT;
    endproperty
    a_first_key: assert property (p_first_key) else $error("first key not taken"); // [RULE2]

    property p_bad_second;
        @(posedge clk) disable iff (rst)
        (key_wr && lock_r == rtcia_pkg::RTCIA_WAIT && sfr_wdata != `RTCIA_KEY_SECOND) |=>
            lock_r == rtcia_pkg::RTCIA_DEAD;
    endproperty
    a_bad_second: assert property (p_bad_second) else $error("bad key not fatal"); // [RULE3]

    property p_relock;
        @(posedge clk) disable iff (rst)
        (key_wr && is_open) |=> lock_r == rtcia_pkg::RTCIA_LOCKED;
    endproperty
    a_relock: assert property (p_relock) else $error("no relock"); // [RULE4]

    property p_dead_sticks;
        @(posedge clk) disable iff (rst)
        lock_r == rtcia_pkg::RTCIA_DEAD |=> lock_r == rtcia_pkg::RTCIA_DEAD;
    endproperty
    a_dead_sticks: assert property (p_dead_sticks) else $error("left disabled"); // [RULE5]

    property p_locked_access;
        @(posedge clk) disable iff (rst)
        (is_locked && dat_wr) |=> lock_r == rtcia_pkg::RTCIA_DEAD && !busy_r;
    endproperty
    a_locked_access: assert property (p_locked_access) else $error("locked access"); // [RULE6]

    property p_len_normal;
        @(posedge clk) disable iff (rst)
        (start && !short_nxt) |=> busy_r [*7] ##1 !busy_r;
    endproperty
    a_len_normal: assert property (p_len_normal) else $error("normal length"); // [RULE14]

    property p_len_short;
        @(posedge clk) disable iff (rst)
        (start && short_nxt) |=> busy_r [*6] ##1 !busy_r;
    endproperty
    a_len_short: assert property (p_len_short) else $error("short length"); // [RULE14]

    property p_autoinc;
        @(posedge clk) disable iff (rst)
        done |=> addr_r == (auto_inc($past(addr_r)) ? $past(addr_r) + 4'h1 : $past(addr_r));
    endproperty
    a_autoinc: assert property (p_autoinc) else $error("address step"); // [RULE16]

    property p_read_data;
        @(posedge clk) disable iff (rst)
        (done && !wr_op_r) |=> data_r == $past(rtc_rdata);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data lost"); // [RULE18]

    property p_autoread;
        @(posedge clk) disable iff (rst)
        (dat_rd && auto_read_enable_r && is_open && !busy_r && !sfr_wr) |=> busy_r && rtc_rd;
    endproperty
    a_autoread: assert property (p_autoread) else $error("autoread missing"); // [RULE11]

    property p_unused_bit;
        @(posedge clk) disable iff (rst)
        (sfr_rd && sfr_addr == `RTCIA_ADR_OFS) |=> !sfr_rdata[`RTCIA_BIT_UNUSED];
    endproperty
    a_unused_bit: assert property (p_unused_bit) else $error("bit 5 set"); // [RULE12]
endmodule // rtcia_window

/* File: rtcia_core_model.sv */
// clock-core register file model on the strobe side of the window
// assumes the window's registered one-cycle rtc_rd and rtc_wr pulses
`timescale 1ns/1ps
module rtcia_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] rtc_addr,
    input wire logic [7:0] rtc_wdata,
    input wire logic rtc_wr,
    input wire logic rtc_rd,
    output logic [7:0] rtc_rdata
);
    logic [7:0] mem [16];
    logic [3:0] addr_q;
    logic [3:0] hold_cnt;

    // outside a read the byte is inverted so a stale sample cannot pass
    assign rtc_rdata = (rtc_rd || hold_cnt != 4'h0) ? mem[rtc_addr] : ~mem[rtc_addr];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                mem[i] <= 8'h10 + 8'(i);
            end
            addr_q <= 4'h0;
            hold_cnt <= 4'h0;
        end else begin
            addr_q <= rtc_addr;
            hold_cnt <= rtc_rd ? 4'h8 : ((hold_cnt != 4'h0) ? hold_cnt - 4'h1 : 4'h0);
            // the window has already stepped its address when the pulse shows
            if (rtc_wr) begin
                mem[addr_q] <= rtc_wdata;
            end
        end
    end
endmodule // rtcia_core_model

/* File: tb_top.sv */
// self-checking bench for the locked indirect-access window
// assumes the design files and rtcia_regs.svh are compiled alongside
`timescale 1ns/1ps
`include "rtcia_regs.svh"
module tb_top;
    logic clk, rst, sfr_wr, sfr_rd, rtc_wr, rtc_rd;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rtc_rdata, rtc_wdata, got;
    logic [3:0] rtc_addr;
    logic [1:0] lock_machine_state;
    int num_errors = 0;
    int comparisons = 0;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    rtcia_window i_dut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .rtc_rdata(rtc_rdata),
        .rtc_addr(rtc_addr), .rtc_wdata(rtc_wdata), .rtc_wr(rtc_wr), .rtc_rd(rtc_rd),
        .lock_machine_state(lock_machine_state));
    rtcia_core_model i_model (.clk(clk), .rst(rst), .rtc_addr(rtc_addr),
        .rtc_wdata(rtc_wdata), .rtc_wr(rtc_wr), .rtc_rd(rtc_rd), .rtc_rdata(rtc_rdata));

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        #1;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1;
        got = sfr_rdata;
        chk(got, e);
    endtask

    // polls the busy flag without starting transfers; bounded
    task automatic idle();
        int n;
        n = 0;
        got = 8'h80;
        while (got[7] !== 1'b0 && n < 20) begin
            @(posedge clk);
            sfr_addr <= `RTCIA_ADR_OFS;
            sfr_rd <= 1'b1;
            @(posedge clk);
            sfr_rd <= 1'b0;
            #1;
            got = sfr_rdata;
            n++;
        end
        chk({7'h00, got[7]}, 8'h00);
    endtask

    // cycles from the taking edge of a data write to the strobe pulse
    task automatic lat(input int e);
        int n;
        n = 0;
        while (rtc_wr !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(8'(n), 8'(e));
    endtask

    task automatic rst_go();
        @(posedge clk);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic finish_test();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        $display("watchdog expired at t=%0t", $time);
        finish_test();
    end

    // the data window is only ever read or written whole, never modified in place
    initial begin
        rst = 1'b1;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rchk(`RTCIA_KEY_OFS, `RTCIA_CODE_LOCKED);
        rchk(`RTCIA_ADR_OFS, `RTCIA_ADR_RST);
        rchk(`RTCIA_DAT_OFS, `RTCIA_DAT_RST);
        wr(`RTCIA_KEY_OFS, `RTCIA_KEY_FIRST);
        rchk(`RTCIA_KEY_OFS, `RTCIA_CODE_WAIT);
        rchk(`RTCIA_KEY_OFS, `RTCIA_CODE_WAIT);
        wr(`RTCIA_KEY_OFS, `RTCIA_KEY_SECOND);
        rchk(`RTCIA_KEY_OFS, `RTCIA_CODE_OPEN);
        chk({6'h00, lock_machine_state}, 8'h02);
        wr(`RTCIA_ADR_OFS, 8'h3A);
        rchk(`RTCIA_ADR_OFS, 8'h1A);
        wr(`RTCIA_DAT_OFS, 8'h77);
        lat(`RTCIA_CYC_SHORT);
        rchk(`RTCIA_ADR_OFS, 8'h1B);
        chk(i_model.mem[10], 8'h77);
        wr(`RTCIA_ADR_OFS, 8'h04);
        wr(`RTCIA_DAT_OFS, 8'h55);
        lat(`RTCIA_CYC_NORMAL);
        rchk(`RTCIA_ADR_OFS, 8'h04);
        chk(i_model.mem[4], 8'h55);
        rchk(`RTCIA_DAT_OFS, 8'h55);
        wr(`RTCIA_ADR_OFS, 8'h82);
        rchk(`RTCIA_ADR_OFS, 8'h82);
        idle();
        rchk(`RTCIA_DAT_OFS, 8'h12);
        rchk(`RTCIA_ADR_OFS, 8'h03);
        wr(`RTCIA_ADR_OFS, 8'hC8);
        idle();
        rchk(`RTCIA_DAT_OFS, 8'h18);
        idle();
        rchk(`RTCIA_DAT_OFS, 8'h19);
        idle();
        rchk(`RTCIA_DAT_OFS, 8'h77);
        idle();
        // busy and short set in one write: the read must already use short timing
        wr(`RTCIA_ADR_OFS, 8'h95);
        rchk(`RTCIA_ADR_OFS, 8'h95);
        rchk(`RTCIA_ADR_OFS, 8'h95);
        @(posedge clk);
        rchk(`RTCIA_ADR_OFS, 8'h15);
        rchk(`RTCIA_DAT_OFS, 8'h15);
        wr(`RTCIA_KEY_OFS, 8'h00);
        rchk(`RTCIA_KEY_OFS, `RTCIA_CODE_LOCKED);
        wr(`RTCIA_KEY_OFS, `RTCIA_KEY_FIRST);
        wr(`RTCIA_KEY_OFS, 8'h12);
        rchk(`RTCIA_KEY_OFS, `RTCIA_CODE_DEAD);
        wr(`RTCIA_KEY_OFS, `RTCIA_KEY_FIRST);
        wr(`RTCIA_KEY_OFS, `RTCIA_KEY_SECOND);
        rchk(`RTCIA_KEY_OFS, `RTCIA_CODE_DEAD);
        rchk(`RTCIA_ADR_OFS, 8'h00);
        rst_go();
        wr(`RTCIA_KEY_OFS, 8'h11);
        rchk(`RTCIA_KEY_OFS, `RTCIA_CODE_DEAD);
        rst_go();
        wr(`RTCIA_DAT_OFS, 8'h01);
        rchk(`RTCIA_KEY_OFS, `RTCIA_CODE_DEAD);
        rst_go();
        rchk(`RTCIA_KEY_OFS, `RTCIA_CODE_LOCKED);
        finish_test();
    end
endmodule // tb_top
